// ---- rtl/nvm_seq_pkg.sv ----
// constants, types and register map of the nvm command sequencer
package nvm_seq_pkg;

  // apb register map (byte addresses)
  localparam logic [7:0] ADDR_COMMAND_INDEX = 8'h00;
  localparam logic [7:0] ADDR_COMMAND_DATA  = 8'h04;
  localparam logic [7:0] ADDR_STATUS        = 8'h08;
  localparam logic [7:0] ADDR_MODE          = 8'h0c;
  localparam logic [7:0] ADDR_MARGIN        = 8'h10;
  localparam logic [7:0] ADDR_PARTITION     = 8'h14;
  localparam logic [7:0] ADDR_SECURITY      = 8'h18;
  localparam logic [7:0] ADDR_POWER         = 8'h1c;

  // status register bit positions
  localparam int STAT_COMPLETE_BIT  = 7;
  localparam int STAT_ACCESS_ERROR_FLAG_BIT    = 5;
  localparam int STAT_PROTVIOL_BIT  = 4;
  localparam int STAT_VERIFY_HI_BIT = 1;
  localparam int STAT_VERIFY_LO_BIT = 0;

  // mode register bit positions
  localparam int MODE_SPECIAL_BIT  = 0;
  localparam int MODE_LOADDATA_BIT = 1;

  // power register bit positions
  localparam int PWR_EE_PENDING_BIT = 0;
  localparam int PWR_STOP_REQ_BIT   = 1;

  // partition register field positions
  localparam int PART_DATA_LSB  = 0;
  localparam int PART_RAM_LSB   = 16;

  // command codes
  localparam logic [7:0] CMD_SET_FIELD_MARGIN = 8'h0e;
  localparam logic [7:0] CMD_FULL_PARTITION   = 8'h0f;
  localparam logic [7:0] CMD_ERASE_VERIFY_SEC = 8'h10;

  // command object indexes
  localparam logic [2:0] IDX_0 = 3'h0;
  localparam logic [2:0] IDX_1 = 3'h1;
  localparam logic [2:0] IDX_2 = 3'h2;
  localparam logic [2:0] IDX_6 = 3'h6;
  localparam logic [2:0] IDX_7 = 3'h7;

  // margin level codes
  localparam logic [15:0] MARGIN_NORMAL  = 16'h0000;
  localparam logic [15:0] MARGIN_USER_1  = 16'h0001;
  localparam logic [15:0] MARGIN_USER_0  = 16'h0002;
  localparam logic [15:0] MARGIN_FIELD_1 = 16'h0003;
  localparam logic [15:0] MARGIN_FIELD_0 = 16'h0004;

  // data flash geometry
  localparam int          DFLASH_SECTORS      = 128;
  localparam int          DFLASH_SECTOR_BYTES = 256;
  localparam logic [15:0] DFLASH_WORDS        =
    16'((DFLASH_SECTORS * DFLASH_SECTOR_BYTES) / 2);
  localparam logic [15:0] EMU_RAM_MAX_SECTORS = 16'h0010;

  // valid block ids in global address [22:16]; arbitrary neutral values
  localparam logic [6:0] BLOCK_PFLASH = 7'h7f;
  localparam logic [6:0] BLOCK_DFLASH = 7'h10;

  // security configuration field address and reset value
  localparam logic [22:0] SECURITY_BYTE_ADDR = 23'h7fff0f;
  localparam logic [7:0]  SECURITY_RESET     = 8'hff;

  // reset values
  localparam logic [15:0] COMMAND_WORD_RESET = 16'h0000;
  localparam logic [2:0]  COMMAND_INDEX_RESET = 3'h0;

  // verification timing: cycles per checked word
  localparam int          WORD_CHECK_NS     = 10;
  localparam int          CLOCK_PERIOD_NS   = 10;
  localparam logic [3:0]  WORD_CHECK_CYCLES =
    4'((WORD_CHECK_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);

  // sequencer states
  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_CHECK  = 4'b0010,
    ST_VERIFY = 4'b0100,
    ST_FINISH = 4'b1000
  } seq_state_type;

  // apb request carrier
  typedef struct packed {
    logic        sel;
    logic        enable;
    logic        write;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } apb_req_type;

  // array read port carrier
  typedef struct packed {
    logic        req;
    logic [22:0] addr;
  } array_req_type;

endpackage

// ---- rtl/nvm_command_sequencer.sv ----
// nvm command sequencer: command object array, launch checks, execution
//
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/10ps
module nvm_command_sequencer
  import nvm_seq_pkg::*;
(
  // clock and reset
  input  wire logic        CLOCK_IN,
  input  wire logic        SRST_IN,
  // apb slave
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [7:0]  PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  output logic      [31:0] PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  // array read port
  output logic             ARRAY_REQ_OUT,
  output logic      [22:0] ARRAY_ADDR_OUT,
  input  wire logic [15:0] ARRAY_DATA_IN,
  input  wire logic        ARRAY_ECC_ERR_IN,
  input  wire logic        ARRAY_ECC_FATAL_IN,
  // margin and security to the array
  output logic      [2:0]  READ_MARGIN_OUT,
  output logic      [1:0]  SECURITY_STATE_OUT,
  // power management
  output logic             WAKE_OUT,
  output logic             STOP_ACK_OUT
);

  apb_req_type   bus;
  seq_state_type state;
  seq_state_type next_state;

  logic [15:0] command_object_array [6];
  logic [2:0]  command_index;
  logic        command_complete_flag;
  logic        access_error_flag;
  logic        protection_violation_flag;
  logic        verify_status_hi;
  logic        verify_status_lo;
  logic        special_mode;
  logic        load_data_active;
  logic        ee_pending;
  logic        stop_request;
  logic [15:0] data_partition_size;
  logic [15:0] emulation_ram_partition_size;
  logic [7:0]  security_config_register;
  logic        security_loaded;
  logic [15:0] block_margin_pf;
  logic [15:0] block_margin_df;
  logic [15:0] words_left;
  logic [15:0] word_addr;
  logic [3:0]  wait_count;
  logic        launch_error;
  logic        acc;
  logic        wr;
  logic        launch;
  logic [7:0]  cmd_code;
  logic [6:0]  blk;

  assign bus      = '{PSEL_IN, PENABLE_IN, PWRITE_IN, PADDR_IN, PWDATA_IN};
  assign acc      = bus.sel & bus.enable;
  assign wr       = acc & bus.write;
  assign cmd_code = command_object_array[IDX_0][15:8];
  assign blk      = command_object_array[IDX_0][6:0];
  // launch only from idle: a one written while busy is no command
  assign launch   = wr & (bus.addr == ADDR_STATUS)
                  & bus.wdata[STAT_COMPLETE_BIT]
                  & command_complete_flag;

  // launch checks, evaluated in the cycle after the launch write
  always_comb begin
    launch_error = 1'b0;
    if (load_data_active) begin
      launch_error = 1'b1;
    end
    unique case (cmd_code)
      CMD_SET_FIELD_MARGIN: begin
        if (command_index != IDX_1) launch_error = 1'b1;
        if (!special_mode) launch_error = 1'b1;
        if (blk != BLOCK_PFLASH && blk != BLOCK_DFLASH) begin
          launch_error = 1'b1;
        end
        if (command_object_array[IDX_1] > MARGIN_FIELD_0) begin
          launch_error = 1'b1;
        end
      end
      CMD_FULL_PARTITION: begin
        if (command_index != IDX_2) launch_error = 1'b1;
        if (!special_mode) launch_error = 1'b1;
        // sizes in sectors of the 128-sector data block
        if (command_object_array[IDX_1] > 16'(DFLASH_SECTORS)) begin
          launch_error = 1'b1;
        end
        if (command_object_array[IDX_2] > EMU_RAM_MAX_SECTORS) begin
          launch_error = 1'b1;
        end
      end
      CMD_ERASE_VERIFY_SEC: begin
        if (command_index != IDX_2) launch_error = 1'b1;
        if (blk != BLOCK_DFLASH) launch_error = 1'b1;
        if (command_object_array[IDX_2] == 16'h0000) launch_error = 1'b1;
        if (32'(command_object_array[IDX_1]) +
            32'(command_object_array[IDX_2]) > 32'(DFLASH_WORDS)) begin
          launch_error = 1'b1;
        end
      end
      default: launch_error = 1'b1;
    endcase
  end

  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE:   if (launch) next_state = ST_CHECK;
      ST_CHECK: begin
        if (launch_error) next_state = ST_FINISH;
        else if (cmd_code == CMD_SET_FIELD_MARGIN) next_state = ST_FINISH;
        else next_state = ST_VERIFY;
      end
      ST_VERIFY: begin
        if (words_left == 16'h0000 && wait_count == 4'h0) begin
          next_state = ST_FINISH;
        end
      end
      ST_FINISH: next_state = ST_IDLE;
      default:   next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK_IN) begin
    if (SRST_IN) state <= ST_IDLE;
    else state <= next_state;
  end

  // complete flag: cleared by launch, set when the sequencer finishes
  always_ff @(posedge CLOCK_IN) begin
    if (SRST_IN) begin
      command_complete_flag <= 1'b1;
    end else if (state == ST_FINISH) begin
      command_complete_flag <= 1'b1;
    end else if (launch) begin
      command_complete_flag <= 1'b0;
    end
  end

  // error flags cleared by every launch, verify flags by all but set-margin; hardware sets win
  always_ff @(posedge CLOCK_IN) begin
    if (SRST_IN) begin
      access_error_flag         <= 1'b0;
      protection_violation_flag <= 1'b0;
      verify_status_hi          <= 1'b0;
      verify_status_lo          <= 1'b0;
    end else if (state == ST_CHECK) begin
      access_error_flag <= launch_error;
    end else if (state == ST_VERIFY && cmd_code == CMD_FULL_PARTITION) begin
      if (ARRAY_ECC_ERR_IN | ARRAY_ECC_FATAL_IN) begin
        verify_status_hi <= 1'b1;
      end
      if (ARRAY_ECC_FATAL_IN) verify_status_lo <= 1'b1;
    end else if (state == ST_VERIFY) begin
      // only answers to a real request count; the closing cycle reads none
      if (ARRAY_DATA_IN != 16'hffff && wait_count == 4'h0
          && words_left != 16'h0000) begin
        verify_status_lo <= 1'b1;
        verify_status_hi <= 1'b1;
      end
    end else if (launch) begin
      access_error_flag         <= 1'b0;
      protection_violation_flag <= 1'b0;
      // set-margin leaves verify status untouched
      if (cmd_code != CMD_SET_FIELD_MARGIN) begin
        verify_status_hi <= 1'b0;
        verify_status_lo <= 1'b0;
      end
    end
  end

  // command index and object array, locked while a command runs
  always_ff @(posedge CLOCK_IN) begin
    if (SRST_IN) begin
      command_index <= COMMAND_INDEX_RESET;
      for (int i = 0; i < 6; i++) begin
        command_object_array[i] <= COMMAND_WORD_RESET;
      end
    end else if (command_complete_flag && !launch) begin
      if (wr && bus.addr == ADDR_COMMAND_INDEX) begin
        command_index <= bus.wdata[2:0];
      end
      if (wr && bus.addr == ADDR_COMMAND_DATA
          && command_index != IDX_6 && command_index != IDX_7) begin
        command_object_array[command_index] <= bus.wdata[15:0];
      end
    end else if (state == ST_VERIFY && cmd_code == CMD_ERASE_VERIFY_SEC) begin
      // remaining word count returned as a result
      command_object_array[IDX_2] <= words_left;
    end
  end

  // verification walker over the selected word range
  always_ff @(posedge CLOCK_IN) begin
    if (SRST_IN) begin
      words_left <= 16'h0000;
      word_addr  <= 16'h0000;
      wait_count <= 4'h0;
    end else if (state == ST_CHECK) begin
      if (cmd_code == CMD_FULL_PARTITION) begin
        words_left <= DFLASH_WORDS;
        word_addr  <= 16'h0000;
      end else begin
        words_left <= command_object_array[IDX_2];
        word_addr  <= command_object_array[IDX_1];
      end
      wait_count <= WORD_CHECK_CYCLES;
    end else if (state == ST_VERIFY) begin
      if (wait_count != 4'h0) begin
        wait_count <= wait_count - 4'h1;
      end else if (words_left != 16'h0000) begin
        words_left <= words_left - 16'h0001;
        word_addr  <= word_addr + 16'h0002;
        wait_count <= WORD_CHECK_CYCLES;
      end
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (SRST_IN) begin
      ARRAY_REQ_OUT  <= 1'b0;
      ARRAY_ADDR_OUT <= 23'h000000;
    end else if (state == ST_VERIFY && words_left != 16'h0000) begin
      ARRAY_REQ_OUT  <= 1'b1;
      // partition always scans the data block, whatever index 000 names
      ARRAY_ADDR_OUT <= {((cmd_code == CMD_FULL_PARTITION) ? BLOCK_DFLASH
                                                          : blk), word_addr};
    end else if (!security_loaded) begin
      ARRAY_REQ_OUT  <= 1'b1;
      ARRAY_ADDR_OUT <= SECURITY_BYTE_ADDR;
    end else begin
      ARRAY_REQ_OUT  <= 1'b0;
    end
  end

  // security byte read while reset releases, array answers next cycle
  always_ff @(posedge CLOCK_IN) begin
    if (SRST_IN) begin
      security_config_register <= SECURITY_RESET;
      security_loaded          <= 1'b0;
    end else if (!security_loaded && ARRAY_REQ_OUT) begin
      security_config_register <= ARRAY_DATA_IN[7:0];
      security_loaded          <= 1'b1;
    end
  end

  // margin selection held per block for later reads
  always_ff @(posedge CLOCK_IN) begin
    if (SRST_IN) begin
      block_margin_pf <= MARGIN_NORMAL;
      block_margin_df <= MARGIN_NORMAL;
    end else if (state == ST_CHECK && !launch_error
                 && cmd_code == CMD_SET_FIELD_MARGIN) begin
      if (blk == BLOCK_DFLASH) block_margin_df <= command_object_array[IDX_1];
      else block_margin_pf <= command_object_array[IDX_1];
    end
  end

  // margin output: bit2 active, bit1 field level, bit0 toward erased
  always_ff @(posedge CLOCK_IN) begin
    if (SRST_IN) begin
      READ_MARGIN_OUT <= 3'h0;
    end else begin
      unique case (block_margin_df)
        MARGIN_USER_1:  READ_MARGIN_OUT <= 3'b101;
        MARGIN_USER_0:  READ_MARGIN_OUT <= 3'b100;
        MARGIN_FIELD_1: READ_MARGIN_OUT <= 3'b111;
        MARGIN_FIELD_0: READ_MARGIN_OUT <= 3'b110;
        default:        READ_MARGIN_OUT <= 3'b000;
      endcase
    end
  end

  // mode, partition and power control registers
  always_ff @(posedge CLOCK_IN) begin
    if (SRST_IN) begin
      special_mode                 <= 1'b0;
      load_data_active             <= 1'b0;
      ee_pending                   <= 1'b0;
      stop_request                 <= 1'b0;
      data_partition_size          <= 16'h0000;
      emulation_ram_partition_size <= 16'h0000;
    end else begin
      if (wr && bus.addr == ADDR_MODE) begin
        special_mode     <= bus.wdata[MODE_SPECIAL_BIT];
        load_data_active <= bus.wdata[MODE_LOADDATA_BIT];
      end
      if (wr && bus.addr == ADDR_POWER) begin
        ee_pending   <= bus.wdata[PWR_EE_PENDING_BIT];
        stop_request <= bus.wdata[PWR_STOP_REQ_BIT];
      end
      if (state == ST_CHECK && !launch_error
          && cmd_code == CMD_FULL_PARTITION) begin
        data_partition_size          <= command_object_array[IDX_1];
        emulation_ram_partition_size <= command_object_array[IDX_2];
      end
    end
  end

  // wait: sequencer never halts; completion is the wake event
  // stop granted only when idle and no emulation work pending
  always_ff @(posedge CLOCK_IN) begin
    if (SRST_IN) begin
      WAKE_OUT           <= 1'b0;
      STOP_ACK_OUT       <= 1'b0;
      SECURITY_STATE_OUT <= 2'b11;
    end else begin
      WAKE_OUT           <= state == ST_FINISH;
      STOP_ACK_OUT       <= stop_request && command_complete_flag
                            && !launch && !ee_pending;
      SECURITY_STATE_OUT <= security_config_register[1:0];
    end
  end

  // apb slave: zero wait states, error on unmapped address
  always_ff @(posedge CLOCK_IN) begin
    if (SRST_IN) begin
      PRDATA_OUT  <= 32'h00000000;
      PREADY_OUT  <= 1'b0;
      PSLVERR_OUT <= 1'b0;
    end else begin
      PREADY_OUT  <= bus.sel & ~bus.enable;
      PSLVERR_OUT <= 1'b0;
      PRDATA_OUT  <= 32'h00000000;
      if (bus.sel && !bus.enable) begin
        unique case (bus.addr)
          ADDR_COMMAND_INDEX: PRDATA_OUT <= {29'h0, command_index};
          ADDR_COMMAND_DATA: begin
            if (command_index != IDX_6 && command_index != IDX_7) begin
              PRDATA_OUT <= {16'h0, command_object_array[command_index]};
            end
          end
          ADDR_STATUS: begin
            PRDATA_OUT[STAT_COMPLETE_BIT]  <= command_complete_flag;
            PRDATA_OUT[STAT_ACCESS_ERROR_FLAG_BIT]    <= access_error_flag;
            PRDATA_OUT[STAT_PROTVIOL_BIT]  <= protection_violation_flag;
            PRDATA_OUT[STAT_VERIFY_HI_BIT] <= verify_status_hi;
            PRDATA_OUT[STAT_VERIFY_LO_BIT] <= verify_status_lo;
          end
          ADDR_MODE: PRDATA_OUT <= {30'h0, load_data_active, special_mode};
          ADDR_MARGIN: PRDATA_OUT <= {block_margin_df, block_margin_pf};
          ADDR_PARTITION: begin
            PRDATA_OUT <= {emulation_ram_partition_size,
                           data_partition_size};
          end
          ADDR_SECURITY: PRDATA_OUT <= {24'h0, security_config_register};
          ADDR_POWER: PRDATA_OUT <= {30'h0, stop_request, ee_pending};
          default: PSLVERR_OUT <= 1'b1;
        endcase
      end
    end
  end

endmodule // nvm_command_sequencer

// ---- testbench/nvm_command_sequencer_asserts.sv ----
// port-level assertions for the nvm command sequencer
`timescale 1ns/10ps
module nvm_seq_asserts
  import nvm_seq_pkg::*;
(
  input wire logic        CLOCK_IN,
  input wire logic        SRST_IN,
  input wire logic        PSEL_IN,
  input wire logic        PENABLE_IN,
  input wire logic        PWRITE_IN,
  input wire logic [7:0]  PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic [31:0] PRDATA_OUT,
  input wire logic        PREADY_OUT,
  input wire logic        PSLVERR_OUT,
  input wire logic        ARRAY_REQ_OUT,
  input wire logic [22:0] ARRAY_ADDR_OUT,
  input wire logic [15:0] ARRAY_DATA_IN,
  input wire logic        ARRAY_ECC_ERR_IN,
  input wire logic        ARRAY_ECC_FATAL_IN,
  input wire logic [2:0]  READ_MARGIN_OUT,
  input wire logic [1:0]  SECURITY_STATE_OUT,
  input wire logic        WAKE_OUT,
  input wire logic        STOP_ACK_OUT
);
  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (SRST_IN);
  sequence s_access;
    PSEL_IN && PENABLE_IN;
  endsequence
  sequence s_fetch;
    ARRAY_REQ_OUT && ARRAY_ADDR_OUT == SECURITY_BYTE_ADDR;
  endsequence
  a_ready_in_access: assert property (s_access |-> PREADY_OUT)
    else $error("no ready in access phase");
  a_ready_one_cycle: assert property (PREADY_OUT |=> !PREADY_OUT)
    else $error("ready held too long");
  a_slverr_with_ready: assert property (PSLVERR_OUT |-> PREADY_OUT)
    else $error("error without ready");
  a_unmapped_error: assert property
    (s_access ##0 (PADDR_IN > 8'h1c) |-> PSLVERR_OUT)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (s_access ##0 (PADDR_IN <= 8'h1c &&
    PADDR_IN[1:0] == 2'b00) |-> !PSLVERR_OUT)
    else $error("mapped access refused");
  a_reset_values: assert property ($fell(SRST_IN) |->
    READ_MARGIN_OUT == 3'h0 && SECURITY_STATE_OUT == 2'b11 && !WAKE_OUT)
    else $error("wrong values out of reset");
  a_security_fetch: assert property ($fell(SRST_IN) |-> ##[0:1] s_fetch)
    else $error("security byte not fetched");
  a_dflash_only: assert property (ARRAY_REQ_OUT &&
    ARRAY_ADDR_OUT != SECURITY_BYTE_ADDR |->
    ARRAY_ADDR_OUT[22:16] == BLOCK_DFLASH)
    else $error("array read outside data flash");
  a_verify_then_done: assert property ($fell(ARRAY_REQ_OUT) &&
    $past(ARRAY_ADDR_OUT[22:16]) == BLOCK_DFLASH |-> ##[0:4] WAKE_OUT)
    else $error("no completion after verify");
  a_wake_pulse: assert property (WAKE_OUT |=> !WAKE_OUT)
    else $error("wake longer than one cycle");
  a_margin_at_done: assert property
    ($changed(READ_MARGIN_OUT) |-> ##[0:3] WAKE_OUT)
    else $error("margin moved outside a command");
  a_stop_when_idle: assert property (STOP_ACK_OUT |-> !ARRAY_REQ_OUT)
    else $error("stop granted while reading");
endmodule // nvm_seq_asserts

bind nvm_command_sequencer nvm_seq_asserts nvm_seq_asserts_i (
  .CLOCK_IN, .SRST_IN, .PSEL_IN, .PENABLE_IN, .PWRITE_IN, .PADDR_IN,
  .PWDATA_IN, .PRDATA_OUT, .PREADY_OUT, .PSLVERR_OUT, .ARRAY_REQ_OUT,
  .ARRAY_ADDR_OUT, .ARRAY_DATA_IN, .ARRAY_ECC_ERR_IN, .ARRAY_ECC_FATAL_IN,
  .READ_MARGIN_OUT, .SECURITY_STATE_OUT, .WAKE_OUT, .STOP_ACK_OUT
);

// ---- testbench/nvm_command_sequencer_bench.sv ----
// self-checking bench for the nvm command sequencer
`timescale 1ns/10ps
module nvm_command_sequencer_bench;
  import nvm_seq_pkg::*;
  logic        clock, srst, psel, penable, pwrite, ready, slverr;
  logic        req, wake, stop_ack, err, ecc, fatal;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  logic [22:0] aaddr, last_addr;
  logic [15:0] adata, sd;
  logic [2:0]  margin, mexp;
  logic [1:0]  sec;
  int num_errors, samples_checked, cycles, wakes, launches;
  int mem[8];

  nvm_command_sequencer nvm_command_sequencer_i (
    .CLOCK_IN(clock), .SRST_IN(srst), .PSEL_IN(psel),
    .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
    .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(ready),
    .PSLVERR_OUT(slverr), .ARRAY_REQ_OUT(req), .ARRAY_ADDR_OUT(aaddr),
    .ARRAY_DATA_IN(adata), .ARRAY_ECC_ERR_IN(ecc),
    .ARRAY_ECC_FATAL_IN(fatal), .READ_MARGIN_OUT(margin),
    .SECURITY_STATE_OUT(sec), .WAKE_OUT(wake), .STOP_ACK_OUT(stop_ack));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic summarize();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t register read %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t output %h expected %h", $time, got, exp);
    end
  endtask

  // entered just after a rising edge; holds the request until ready
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (ready !== 1'b1 && n < 20);
    if (n >= 20) num_errors++;
    rd = prdata;
    err = slverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clock);
  endtask

  task automatic ld(input int i, input int v);
    apb(1'b1, ADDR_COMMAND_INDEX, 32'(i));
    apb(1'b1, ADDR_COMMAND_DATA, 32'(v));
  endtask

  task automatic done();
    int n;
    n = 0;
    do begin
      apb(1'b0, ADDR_STATUS, 32'h0);
      n++;
    // a full partition scan takes about 33k cycles
    end while (rd[7] !== 1'b1 && n < 12000);
  endtask

  task automatic go();
    apb(1'b1, ADDR_STATUS, 32'h80);
    launches++;
    done();
  endtask

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  always @(posedge clock) begin
    cycles++;
    if (wake === 1'b1) wakes++;
    if (req === 1'b1) last_addr = aaddr;
    // two full partition scans dominate the run time
    if (cycles > 80000) begin
      num_errors++;
      summarize();
    end
  end

  initial begin
    int modes[7] = '{1, 3, 0, 1, 1, 3, 1};
    int blks[7]  = '{16, 16, 16, 5, 16, 16, 16};
    int codes[7] = '{14, 14, 14, 14, 15, 15, 16};
    int lasts[7] = '{0, 1, 1, 1, 1, 2, 2};
    int n, st, dsz, rsz;
    seed = 32'h1df8;
    srst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; ecc = 1'b0; fatal = 1'b0;
    sd = 16'(rnd());
    adata = sd;
    repeat (20) @(posedge clock);
    srst <= 1'b0;
    repeat (4) @(posedge clock);
    chk_pin(sec, sd[1:0]);
    apb(1'b0, ADDR_SECURITY, 32'h0);
    chk_reg(rd, {24'h0, sd[7:0]});
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk_reg(rd, 32'h80);
    apb(1'b0, 8'h40, 32'h0);
    chk_pin(err, 1'b1);
    $display("reset and map test done");
    for (int i = 0; i < 8; i++) begin
      mem[i] = int'(rnd() & 32'hffff);
      ld(i, mem[i]);
      // the two unimplemented slots must drop the write and read zero
      if (i > 5) mem[i] = 0;
    end
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, ADDR_COMMAND_INDEX, 32'(i));
      apb(1'b0, ADDR_COMMAND_DATA, 32'h0);
      chk_reg(rd, 32'(mem[i]));
    end
    $display("command array test done");
    apb(1'b1, ADDR_MODE, 32'h1);
    mexp = 3'h0;
    for (int c = 0; c < 6; c++) begin
      ld(0, 16'h0e10);
      ld(1, c);
      go();
      if (c < 5) mexp = (c == 0) ? 3'h0 : {1'b1, c > 2, c[0]};
      chk_reg(rd, c > 4 ? 32'ha0 : 32'h80);
      chk_pin(margin, mexp);
    end
    apb(1'b0, ADDR_MARGIN, 32'h0);
    chk_reg(rd, {MARGIN_FIELD_0, MARGIN_NORMAL});
    $display("margin test done");
    for (int k = 0; k < 7; k++) begin
      apb(1'b1, ADDR_MODE, 32'(modes[k]));
      ld(0, (codes[k] << 8) | blks[k]);
      ld(2, 0);
      ld(1, 1);
      apb(1'b1, ADDR_COMMAND_INDEX, 32'(lasts[k]));
      go();
      chk_reg(rd, 32'ha0);
      chk_pin(margin, mexp);
    end
    $display("error test done");
    apb(1'b1, ADDR_MODE, 32'h0);
    for (int p = 0; p < 2; p++) begin
      adata <= p ? 16'h0000 : 16'hffff;
      n = 6 + int'(rnd() % 3);
      st = int'(rnd() & 32'hff);
      ld(0, 16'h1010);
      ld(1, st);
      ld(2, n);
      apb(1'b1, ADDR_STATUS, 32'h80);
      launches++;
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk_reg(rd[7], 1'b0);
      apb(1'b1, ADDR_POWER, 32'h2);
      chk_pin(stop_ack, 1'b0);
      ld(0, 0);
      done();
      chk_reg(rd, p ? 32'h83 : 32'h80);
      chk_pin(stop_ack, 1'b1);
      chk_pin(32'(last_addr),
              {9'h0, BLOCK_DFLASH, 16'(st + 2 * (n - 1))});
      apb(1'b1, ADDR_COMMAND_INDEX, 32'h0);
      apb(1'b0, ADDR_COMMAND_DATA, 32'h0);
      chk_reg(rd, 32'h1010);
      apb(1'b1, ADDR_POWER, 32'h3);
      // the grant drops one edge after the pending bit lands
      @(posedge clock);
      chk_pin(stop_ack, 1'b0);
      apb(1'b1, ADDR_POWER, 32'h0);
    end
    $display("erase verify and stop test done");
    apb(1'b1, ADDR_MODE, 32'h1);
    for (int p = 0; p < 2; p++) begin
      dsz = int'(rnd() % 129);
      rsz = int'(rnd() % 17);
      ecc <= (p == 0);
      fatal <= (p == 1);
      ld(0, {CMD_FULL_PARTITION, 1'b0, BLOCK_DFLASH});
      ld(1, dsz);
      ld(2, rsz);
      go();
      ecc <= 1'b0;
      fatal <= 1'b0;
      chk_reg(rd, p ? 32'h83 : 32'h82);
      chk_pin(32'(last_addr),
              {9'h0, BLOCK_DFLASH, 16'(DFLASH_WORDS * 2 - 2)});
      apb(1'b0, ADDR_PARTITION, 32'h0);
      chk_reg(rd, {16'(rsz), 16'(dsz)});
    end
    $display("partition test done");
    chk_pin(wakes, launches);
    summarize();
  end
endmodule // nvm_command_sequencer_bench
